/* File: hdl/serial_port.sv */
// Transmit and receive datapath of a serial port with an APB register slave.
//
// Summary of operation
// R1 - Transmit enable takes over the transmit pin.
// R2 - Synchronous mode transmits on the serial clock.
// R3 - Data write loads buffer; shifter takes it idle.
// R4 - Shifter sends one frame at configured rate.
// R5 - Unused upper transmit bits are ignored.
// R6 - Ninth bit comes from transmit ninth bit.
// R7 - Buffer empty flag clears on write, sets on move.
// R8 - Buffer empty request holds while flag set.
// R9 - Handler writes data or clears enable.
// R10 - Transmit complete sets when frame and buffer empty.
// R11 - Transmit complete clears on service or one.
// R12 - Transmit complete request follows its flag.
// R13 - Parity bit goes after last data bit.
// R14 - Transmit disable waits until shifter, buffer empty.
// R15 - Receive enable takes over the receive pin.
// R16 - Synchronous receiver samples on serial clock.
// R17 - Receiver starts on valid start bit.
// R18 - Second stop bit is ignored.
// R19 - First stop bit moves data to buffer.
// R20 - Unused upper receive bits read zero.
// R21 - Software configures before starting traffic.
// R22 - Software writes zero to buffer empty flag.
// R23 - Frame is start, LSB first data, parity, stops.
// R24 - Parity is data xor, inverted when odd.
// R25 - Bit period follows divider and mode.
// R26 - Receive complete shows unread buffered data.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "serial_port_params.svh"
module serial_port (
  // Clock and reset.
  input  wire logic                      CLK,
  input  wire logic                      RST_N,
  // APB slave.
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [11:0]               PADDR,
  input  wire serial_port_pkg::word_t    PWDATA,
  output logic                           PREADY,
  output serial_port_pkg::word_t         PRDATA,
  output logic                           PSLVERR,
  // Serial lines.
  input  wire logic                      RXD_IN,
  output logic                           TXD_OUT,
  output logic                           TXD_OE,
  output logic                           RXD_OWNED,
  input  wire logic                      XCK_IN,
  output logic                           XCK_OUT,
  output logic                           XCK_OE,
  // Interrupt requests.
  output logic                           IRQ_UDRE,
  output logic                           IRQ_TXC,
  output logic                           IRQ_RXC,
  input  wire logic                      IRQ_TXC_ACK
);
  import serial_port_pkg::*;

  logic [7:0]  ctrl_b_reg, ctrl_c_reg;
  logic [11:0] baud_reg;
  logic        dbl_reg, txc_reg, udre_reg;
  logic [8:0]  txbuf_reg, rxbuf_reg;
  logic        rxc_reg;
  logic        tx_on_reg, rx_on_reg;
  tx_state_t   tx_state_reg;
  rx_state_t   rx_state_reg;
  logic [8:0]  tx_shift_reg, rx_shift_reg;
  logic [3:0]  tx_cnt_reg, rx_cnt_reg;
  logic        tx_par_reg;
  logic [11:0] baud_cnt_reg;
  logic [4:0]  ovs_cnt_reg, rx_ovs_reg;
  logic [2:0]  rxd_sync_reg, xck_sync_reg;
  logic        xck_gen_reg;

  // Number of data bits from the character size code.
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    case (code)
      3'h0:    data_bits = 4'h5;
      3'h1:    data_bits = 4'h6;
      3'h2:    data_bits = 4'h7;
      3'h7:    data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction : data_bits

  // Mask of valid data bits for a number of data bits.
  function automatic logic [8:0] data_mask(input logic [3:0] n);
    data_mask = 9'((10'h001 << n) - 10'h001);
  endfunction : data_mask

  logic [2:0] size_code;
  logic [3:0] nbits;
  logic       sync_mode, sync_master;
  logic       wr, rd;
  logic       wr_data, rd_data, tick, tx_bit_en, rx_edge, rx_half;
  logic       tx_load, tx_done, rx_done;
  logic [4:0] ovs;
  assign size_code   = {ctrl_b_reg[`CB_SZ2], ctrl_c_reg[`CC_SZ_HI], ctrl_c_reg[`CC_SZ_LO]};
  assign nbits       = data_bits(size_code);
  assign sync_mode   = ctrl_c_reg[`CC_SYNC];
  assign sync_master = sync_mode && XCK_OE;
  assign wr          = PSEL && PENABLE && PWRITE;
  assign rd          = PSEL && PENABLE && !PWRITE;
  assign wr_data     = wr && (PADDR == `OFS_DATA);
  assign rd_data     = rd && (PADDR == `OFS_DATA);
  assign ovs         = sync_mode ? `OVS_SYNC : (dbl_reg ? `OVS_DOUBLE : `OVS_NORMAL);

  // Pin synchronisers; only the second and third stages are read.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rxd_sync_reg <= 3'h7;
      xck_sync_reg <= 3'h0;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[1:0], RXD_IN};
      xck_sync_reg <= {xck_sync_reg[1:0], XCK_IN};
    end
  end

  // Baud divider: tick every divider+1 cycles, oversample counter divides by the mode factor.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      baud_cnt_reg <= 12'h000;
      ovs_cnt_reg  <= 5'h00;
      xck_gen_reg  <= 1'b0;
    end else if (baud_cnt_reg >= baud_reg) begin
      baud_cnt_reg <= 12'h000;
      ovs_cnt_reg  <= (ovs_cnt_reg + 5'h01 >= ovs) ? 5'h00 : ovs_cnt_reg + 5'h01; // R25
      if (sync_mode) begin
        xck_gen_reg <= ~xck_gen_reg;
      end
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 12'h001;
    end
  end
  assign tick = (baud_cnt_reg >= baud_reg);

  // Synchronous clock edges: master uses its own generated clock, slave the synchronised pin.
  logic sclk_now, sclk_prev_reg, change_edge, sample_edge;
  assign sclk_now = sync_master ? xck_gen_reg : xck_sync_reg[1];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_now;
    end
  end
  assign change_edge = (sclk_now != sclk_prev_reg) && (sclk_now ^ ctrl_c_reg[`CC_CPOL]); // R2
  assign sample_edge = (sclk_now != sclk_prev_reg) && !(sclk_now ^ ctrl_c_reg[`CC_CPOL]); // R16
  assign tx_bit_en   = sync_mode ? change_edge : (tick && ovs_cnt_reg + 5'h01 >= ovs); // R4 R25
  assign rx_edge     = sync_mode ? sample_edge : tick;
  assign rx_half     = sync_mode ? sample_edge : (rx_ovs_reg == {1'b0, ovs[4:1]});

  // Control registers written over APB.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_b_reg <= 8'h00;
      ctrl_c_reg <= `CTRL_C_RESET;
      baud_reg   <= `BAUD_RESET;
      dbl_reg    <= 1'b0;
    end else if (wr) begin
      case (PADDR)
        `OFS_CTRL_B: ctrl_b_reg <= PWDATA[7:0];
        `OFS_CTRL_C: ctrl_c_reg <= PWDATA[7:0];
        `OFS_BAUD:   baud_reg   <= PWDATA[11:0];
        `OFS_STATUS: dbl_reg    <= PWDATA[`ST_DBL];
        default: ;
      endcase
    end
  end

  // Transmitter ownership of the pin; disable waits for shifter and buffer to drain.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_on_reg <= 1'b0;
    end else if (ctrl_b_reg[`CB_TXEN]) begin
      tx_on_reg <= 1'b1; // R1
    end else if (tx_state_reg == TX_IDLE && udre_reg && !tx_load) begin
      tx_on_reg <= 1'b0; // R14
    end
  end

  // Transmit buffer and its empty flag.
  assign tx_load = tx_on_reg && !udre_reg && (tx_state_reg == TX_IDLE || tx_done); // R3
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      txbuf_reg <= 9'h000;
      udre_reg  <= 1'b1;
    end else if (wr_data) begin
      txbuf_reg <= {ctrl_b_reg[`CB_TX9], PWDATA[7:0]} & data_mask(nbits); // R3 R5 R6
      udre_reg  <= 1'b0; // R7
    end else if (tx_load) begin
      udre_reg  <= 1'b1; // R7
    end
  end

  // Transmit shifter.
  // The frame ends when the last stop bit has stood a full bit period.
  assign tx_done = tx_bit_en && tx_state_reg == TX_STOP && tx_cnt_reg == 4'h1;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 9'h000;
      tx_cnt_reg   <= 4'h0;
      tx_par_reg   <= 1'b0;
      TXD_OUT      <= 1'b1;
    end else if (tx_load) begin
      tx_state_reg <= tx_done ? TX_DATA : TX_START; // R3
      tx_shift_reg <= txbuf_reg;
      tx_par_reg   <= ^txbuf_reg ^ ctrl_c_reg[`CC_PAR_ODD]; // R24
      tx_cnt_reg   <= 4'h0;
      if (tx_done) begin
        TXD_OUT <= 1'b0; // R23
      end
    end else if (tx_bit_en) begin
      case (tx_state_reg)
        TX_START: begin
          TXD_OUT      <= 1'b0; // R23
          tx_state_reg <= TX_DATA;
        end
        TX_DATA: begin
          TXD_OUT      <= tx_shift_reg[0]; // R23
          tx_shift_reg <= tx_shift_reg >> 1;
          tx_cnt_reg   <= tx_cnt_reg + 4'h1;
          if (tx_cnt_reg + 4'h1 == nbits) begin
            tx_state_reg <= ctrl_c_reg[`CC_PAR_EN] ? TX_PARITY : TX_STOP;
            tx_cnt_reg   <= ctrl_c_reg[`CC_STOP2] ? 4'h3 : 4'h2;
          end
        end
        TX_PARITY: begin
          TXD_OUT      <= tx_par_reg; // R13
          tx_state_reg <= TX_STOP;
        end
        TX_STOP: begin
          TXD_OUT    <= 1'b1; // R23
          tx_cnt_reg <= tx_cnt_reg - 4'h1;
          if (tx_cnt_reg == 4'h1) begin
            tx_state_reg <= TX_IDLE;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Transmit complete flag: set wins over clears.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      txc_reg <= 1'b0;
    end else if (tx_done && udre_reg) begin
      txc_reg <= 1'b1; // R10
    end else if (IRQ_TXC_ACK || (wr && PADDR == `OFS_STATUS && PWDATA[`ST_TXC])) begin
      txc_reg <= 1'b0; // R11
    end
  end

  // Receiver: start detect, sampling, move to buffer.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_on_reg    <= 1'b0;
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= 9'h000;
      rx_cnt_reg   <= 4'h0;
      rx_ovs_reg   <= 5'h00;
    end else if (!ctrl_b_reg[`CB_RXEN]) begin
      rx_on_reg    <= 1'b0;
      rx_state_reg <= RX_IDLE;
    end else begin
      rx_on_reg <= 1'b1; // R15
      if (rx_edge) begin
        rx_ovs_reg <= (rx_ovs_reg + 5'h01 >= ovs) ? 5'h00 : rx_ovs_reg + 5'h01;
      end
      case (rx_state_reg)
        RX_IDLE: if (rx_edge && !rxd_sync_reg[2]) begin
          rx_state_reg <= sync_mode ? RX_DATA : RX_START; // R16 R17
          rx_ovs_reg   <= 5'h01;
          rx_cnt_reg   <= 4'h0;
        end
        RX_START: if (rx_edge && (rx_half || sync_mode)) begin
          rx_state_reg <= rxd_sync_reg[2] ? RX_IDLE : RX_DATA; // R17
          rx_ovs_reg   <= {1'b0, ovs[4:1]} + 5'h01;
        end
        RX_DATA: if (rx_edge && (sync_mode || rx_half)) begin
          rx_shift_reg <= {rxd_sync_reg[2], rx_shift_reg[8:1]}; // R17
          rx_cnt_reg   <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg + 4'h1 == nbits + {3'h0, ctrl_c_reg[`CC_PAR_EN]}) begin
            rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP: if (rx_edge && (sync_mode || rx_half)) begin
          rx_state_reg <= RX_IDLE; // R18
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end
  assign rx_done = rx_on_reg && ctrl_b_reg[`CB_RXEN] && rx_state_reg == RX_STOP
                   && rx_edge && (sync_mode || rx_half);

  // Receive buffer: aligned data, upper bits zero; new data wins over a read.
  logic [3:0] rx_len;
  logic [8:0] rx_aligned;
  assign rx_len     = nbits + {3'h0, ctrl_c_reg[`CC_PAR_EN]};
  assign rx_aligned = 9'(rx_shift_reg >> (4'h9 - rx_len)) & data_mask(nbits); // R20
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rxbuf_reg <= 9'h000;
      rxc_reg   <= 1'b0;
    end else if (rx_done) begin
      rxbuf_reg <= rx_aligned; // R19
      rxc_reg   <= 1'b1; // R26
    end else if (!ctrl_b_reg[`CB_RXEN] || rd_data) begin
      rxc_reg   <= 1'b0; // R26
    end
  end

  // APB read data, single wait-free access.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          `OFS_DATA:   PRDATA <= {24'h0, rxbuf_reg[7:0]}; // R19 R20
          `OFS_STATUS: PRDATA <= {24'h0, rxc_reg, txc_reg, udre_reg, 3'h0, dbl_reg, 1'b0};
          `OFS_CTRL_B: PRDATA <= {24'h0, ctrl_b_reg[7:2], rxbuf_reg[8], ctrl_b_reg[0]};
          `OFS_CTRL_C: PRDATA <= {24'h0, ctrl_c_reg};
          `OFS_BAUD:   PRDATA <= {20'h0, baud_reg};
          default:     PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Registered pin controls and interrupt requests.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TXD_OE    <= 1'b0;
      RXD_OWNED <= 1'b0;
      XCK_OUT   <= 1'b0;
      XCK_OE    <= 1'b0;
      IRQ_UDRE  <= 1'b0;
      IRQ_TXC   <= 1'b0;
      IRQ_RXC   <= 1'b0;
    end else begin
      TXD_OE    <= tx_on_reg; // R1 R14
      RXD_OWNED <= rx_on_reg; // R15
      XCK_OUT   <= xck_gen_reg;
      XCK_OE    <= sync_mode; // R2
      IRQ_UDRE  <= udre_reg && ctrl_b_reg[`CB_UDRIE]; // R8
      IRQ_TXC   <= txc_reg && ctrl_b_reg[`CB_TXCIE] && !IRQ_TXC_ACK; // R12
      IRQ_RXC   <= rxc_reg;
    end
  end

endmodule : serial_port

/* File: inc/serial_port_params.svh */
// Register offsets, field positions, reset values and timing figures of the serial port.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
`define OFS_DATA        12'h000
`define OFS_STATUS      12'h004
`define OFS_CTRL_B      12'h008
`define OFS_CTRL_C      12'h00C
`define OFS_BAUD        12'h010
`define ST_RXC          7
`define ST_TXC          6
`define ST_UDRE         5
`define ST_DBL          1
`define CB_TXCIE        6
`define CB_UDRIE        5
`define CB_RXEN         4
`define CB_TXEN         3
`define CB_SZ2          2
`define CB_RX9          1
`define CB_TX9          0
`define CC_SYNC         6
`define CC_PAR_EN       5
`define CC_PAR_ODD      4
`define CC_STOP2        3
`define CC_SZ_HI        2
`define CC_SZ_LO        1
`define CC_CPOL         0
`define CTRL_C_RESET    8'h06
`define BAUD_RESET      12'h000
`define OVS_NORMAL      5'h10
`define OVS_DOUBLE      5'h08
`define OVS_SYNC        5'h02
`endif

/* File: inc/serial_port_pkg.sv */
// Types shared by the serial port design.
package serial_port_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef logic [31:0] word_t;
endpackage : serial_port_pkg

/* File: tb/serial_port_monitor.sv */
// Bus and serial line checks on the serial port top ports.
`timescale 1ns/100ps
module serial_port_monitor (
  // Clock, reset and bus.
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Serial line and events.
  input wire logic TXD_OUT,
  input wire logic TXD_OE,
  input wire logic IRQ_TXC,
  input wire logic IRQ_TXC_ACK
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  a_no_slave_error: assert property (PREADY |-> !PSLVERR)
    else $error("slave error raised");
  a_bit_held: assert property (TXD_OE && $changed(TXD_OUT) |=> $stable(TXD_OUT))
    else $error("serial bit too short");
  a_pin_kept_busy: assert property (TXD_OE && !TXD_OUT |=> TXD_OE)
    else $error("pin released mid frame");
  a_ack_clears_done: assert property (IRQ_TXC_ACK && IRQ_TXC |-> ##[1:2] !IRQ_TXC)
    else $error("complete not cleared");
  a_done_line_idle: assert property ($rose(IRQ_TXC) |-> TXD_OUT)
    else $error("complete before stop");
endmodule : serial_port_monitor

/* File: tb/serial_peer.sv */
// Remote transceiver that decodes transmit frames and sends receive frames.
`timescale 1ns/100ps
module serial_peer (
  // Clock and serial lines.
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  int          bit_cycles = 16;
  int          frame_bits = 9;
  int          frames     = 0;
  logic [11:0] got;
  initial rxd = 1'b1;
  // Samples each frame mid-bit, data LSB first after the start bit.
  always begin
    @(negedge txd);
    repeat (bit_cycles / 2) @(posedge clk);
    got = '1;
    for (int i = 0; i < frame_bits; i++) begin
      repeat (bit_cycles) @(posedge clk);
      got[i] = txd;
    end
    frames++;
  end
  // Sends start, n data bits LSB first, then two stop bits.
  task automatic send(input logic [8:0] d, input int n);
    for (int i = -1; i <= n + 1; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i < n) ? d[i] : 1'b1;
      repeat (bit_cycles) @(posedge clk);
    end
  endtask : send
endmodule : serial_peer

/* File: tb/serial_port_test.sv */
// Self-checking bench for the serial port datapath.
`timescale 1ns/100ps
`include "serial_port_params.svh"
module serial_port_test;
  import serial_port_pkg::*;
  logic        CLK;
  logic        RST_N;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [11:0] PADDR;
  word_t       PWDATA;
  word_t       PRDATA;
  word_t       q;
  logic        PREADY;
  logic        PSLVERR;
  logic        TXD_OUT;
  logic        TXD_OE;
  logic        RXD_OWNED;
  logic        XCK_OUT;
  logic        XCK_OE;
  logic        xck_seen;
  logic        IRQ_UDRE;
  logic        IRQ_TXC;
  logic        IRQ_RXC;
  logic        IRQ_TXC_ACK;
  logic        rxd;
  int          miscompares  = 0;
  int          total_checks = 0;
  logic [7:0]  cc [4] = '{8'h46, 8'h20, 8'h34, 8'h06};
  logic [7:0]  cb [4] = '{8'h08, 8'h08, 8'h08, 8'h0D};
  logic [7:0]  st [4] = '{8'h00, 8'h00, 8'h02, 8'h00};
  logic [7:0]  bd [4] = '{8'h03, 8'h02, 8'h01, 8'h00};
  logic [8:0]  ex [4] = '{9'h0A5, 9'h0F5, 9'h0C3, 9'h1F2};
  int          nb [4] = '{8, 5, 7, 9};
  wire         txd_line = TXD_OE ? TXD_OUT : 1'b1;
  serial_port dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .RXD_IN(rxd), .TXD_OUT(TXD_OUT), .TXD_OE(TXD_OE), .RXD_OWNED(RXD_OWNED), .XCK_IN(1'b0),
    .XCK_OUT(XCK_OUT), .XCK_OE(XCK_OE), .IRQ_UDRE(IRQ_UDRE), .IRQ_TXC(IRQ_TXC), .IRQ_RXC(IRQ_RXC),
    .IRQ_TXC_ACK(IRQ_TXC_ACK));
  serial_peer peer (.clk(CLK), .txd(txd_line), .rxd(rxd));
  task automatic apb(input logic wr, input logic [11:0] a, input word_t d);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  task automatic chk(input string n, input word_t e, input word_t g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic frames_to(input int n);
    while (peer.frames < n) @(posedge CLK);
  endtask : frames_to
  function automatic word_t framed(logic [8:0] d, int n, logic par, logic odd);
    word_t f;
    f = 32'h00000FFF;
    for (int i = 0; i < n; i++) begin
      f[i] = d[i];
      odd ^= d[i];
    end
    if (par) f[n] = odd;
    return f;
  endfunction : framed
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    close_out;
  end
  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    IRQ_TXC_ACK = 1'b0;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    apb(0, `OFS_CTRL_C, 32'h0);
    chk("ctrl_c", 32'h06, q);
    apb(0, `OFS_STATUS, 32'h0);
    chk("status", 32'h20, q);
    apb(0, 12'h020, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("txd_oe", 32'h0, TXD_OE);
    $display("test reset done");
    apb(1, `OFS_CTRL_B, 32'h68);
    apb(1, `OFS_DATA, 32'h55);
    while (TXD_OUT !== 1'b0) @(posedge CLK);
    chk("txd_oe", 32'h1, TXD_OE);
    apb(1, `OFS_DATA, 32'h3C);
    apb(0, `OFS_STATUS, 32'h0);
    chk("status", 32'h00, q);
    chk("irq_udre", 32'h0, IRQ_UDRE);
    frames_to(1);
    chk("frame", framed(9'h055, 8, 0, 0), peer.got);
    frames_to(2);
    chk("frame", framed(9'h03C, 8, 0, 0), peer.got);
    while (IRQ_TXC !== 1'b1) @(posedge CLK);
    apb(0, `OFS_STATUS, 32'h0);
    chk("status", 32'h60, q);
    chk("irq_udre", 32'h1, IRQ_UDRE);
    chk("irq_txc", 32'h1, IRQ_TXC);
    IRQ_TXC_ACK <= 1'b1;
    @(posedge CLK);
    IRQ_TXC_ACK <= 1'b0;
    repeat (3) @(posedge CLK);
    chk("irq_txc", 32'h0, IRQ_TXC);
    apb(1, `OFS_CTRL_B, 32'h48);
    @(posedge CLK);
    chk("irq_udre", 32'h0, IRQ_UDRE);
    $display("test back to back done");
    for (int c = 0; c < 4; c++) begin
      apb(1, `OFS_CTRL_C, {24'h0, cc[c]});
      apb(1, `OFS_STATUS, {24'h0, st[c]});
      apb(1, `OFS_BAUD, {24'h0, bd[c]});
      apb(1, `OFS_CTRL_B, {24'h0, cb[c]});
      peer.bit_cycles = (cc[c][6] ? 2 : st[c][1] ? 8 : 16) * (bd[c] + 1);
      peer.frame_bits = nb[c] + cc[c][5] + 1;
      apb(1, `OFS_DATA, {24'h0, ex[c][7:0]});
      frames_to(3 + c);
      chk("frame", framed(ex[c], nb[c], cc[c][5], cc[c][4]), peer.got);
      chk("xck_oe", {31'h0, cc[c][6]}, {31'h0, XCK_OE});
      xck_seen = XCK_OUT;
      repeat (bd[c] + 1) @(posedge CLK);
      chk("xck_out", {31'h0, xck_seen ^ cc[c][6]}, {31'h0, XCK_OUT});
      repeat (peer.bit_cycles) @(posedge CLK);
      apb(0, `OFS_STATUS, 32'h0);
      chk("status", {24'h0, st[c] | 8'h60}, q);
      apb(1, `OFS_STATUS, {24'h0, st[c] | 8'h40});
      apb(0, `OFS_STATUS, 32'h0);
      chk("status", {24'h0, st[c] | 8'h20}, q);
    end
    $display("test formats done");
    apb(1, `OFS_BAUD, 32'h0);
    apb(1, `OFS_STATUS, 32'h0);
    peer.bit_cycles = 16;
    peer.frame_bits = 9;
    apb(1, `OFS_CTRL_B, 32'h08);
    apb(1, `OFS_DATA, 32'h81);
    apb(1, `OFS_CTRL_B, 32'h00);
    chk("txd_oe", 32'h1, TXD_OE);
    frames_to(7);
    chk("frame", framed(9'h081, 8, 0, 0), peer.got);
    repeat (24) @(posedge CLK);
    chk("txd_oe", 32'h0, TXD_OE);
    $display("test disable done");
    apb(1, `OFS_STATUS, 32'h40);
    apb(1, `OFS_CTRL_C, 32'h0E);
    apb(1, `OFS_CTRL_B, 32'h10);
    repeat (2) @(posedge CLK);
    chk("rxd_owned", 32'h1, RXD_OWNED);
    peer.send(9'h0A7, 8);
    chk("irq_rxc", 32'h1, IRQ_RXC);
    apb(0, `OFS_STATUS, 32'h0);
    chk("status", 32'hA0, q);
    apb(0, `OFS_DATA, 32'h0);
    chk("rx_data", 32'hA7, q);
    apb(0, `OFS_STATUS, 32'h0);
    chk("status", 32'h20, q);
    apb(1, `OFS_CTRL_C, 32'h00);
    peer.send(9'h1F5, 5);
    chk("irq_rxc", 32'h1, IRQ_RXC);
    apb(0, `OFS_DATA, 32'h0);
    chk("rx_data", 32'h15, q);
    $display("test receive done");
    close_out;
  end
endmodule : serial_port_test
bind serial_port serial_port_monitor mon (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .TXD_OUT(TXD_OUT), .TXD_OE(TXD_OE), .IRQ_TXC(IRQ_TXC),
  .IRQ_TXC_ACK(IRQ_TXC_ACK));
